/* File: hw/fcp_defines.svh */
// Constants shared by the four-channel PWM generator
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// ************************************************************
// Widths
// ************************************************************
`define FCP_CNT_W 10
`define FCP_NUM_CH 4
`define FCP_PER_HI_W 2
`define FCP_PER_LO_W 8
`define FCP_SYNC_W 2

// ************************************************************
// Reset values and special compare codes
// ************************************************************
`define FCP_CNT_RST 10'h000
`define FCP_PER_RST 10'h3FF
`define FCP_CMP_RST 10'h000
`define FCP_CMP_MIN 10'h000
`define FCP_CMP_MAX 10'h3FF
`define FCP_PWM_RST 4'h0
`define FCP_SYNC_RST 2'h0
`define FCP_STRAP_WAIT 2'h2

`endif

/* File: hw/fcp_pkg.sv */
// Types for the four-channel PWM generator
`include "fcp_defines.svh"

package fcp_pkg;

    // ************************************************************
    // Data and state types
    // ************************************************************
    typedef logic [`FCP_CNT_W-1:0] fcp_cnt_t;
    typedef logic [`FCP_NUM_CH-1:0] fcp_lvl_t;
    typedef logic [`FCP_NUM_CH-1:0][`FCP_CNT_W-1:0] fcp_cmp_arr_t;

    // Generator control states, one-hot
    typedef enum logic [3:0] {
        ST_INIT  = 4'b0001,
        ST_STOP  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_BRAKE = 4'b1000
    } fcp_state_e;

endpackage : fcp_pkg

/* File: hw/fcp_cnt_if.sv */
// Counter timing bundle between the period counter and the channels
interface fcp_cnt_if;
    import fcp_pkg::*;

    fcp_cnt_t cnt;
    logic uf_evt;
    logic apply;

    // Counter drives, channels listen
    modport src (output cnt, output uf_evt, output apply);
    modport snk (input cnt, input uf_evt, input apply);

endinterface : fcp_cnt_if

/* File: hw/fcp_counter.sv */
// Shared 10-bit down counter with period reload
`include "fcp_defines.svh"

module fcp_counter (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic load_bit,
    input wire fcp_pkg::fcp_cnt_t period_value,
    fcp_cnt_if.src tim
);
    import fcp_pkg::*;

    fcp_cnt_t cnt_ff;
    fcp_cnt_t shadow_ff;

    // ************************************************************
    // Underflow and load decode
    // ************************************************************
    // Underflow only while running, so a stopped counter raises nothing
    assign tim.uf_evt = run && (cnt_ff == `FCP_CNT_RST);
    assign tim.apply = tim.uf_evt && load_bit;
    assign tim.cnt = cnt_ff;

    // Counter register takes the period only on a loaded underflow
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shadow_ff <= `FCP_PER_RST;
        end else if (tim.apply) begin
            shadow_ff <= period_value;
        end
    end

    // One step per clock, no prescaler; hold when stopped
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= `FCP_CNT_RST;
        end else if (tim.apply) begin
            cnt_ff <= period_value;
        end else if (tim.uf_evt) begin
            cnt_ff <= shadow_ff;
        end else if (run) begin
            cnt_ff <= cnt_ff - 10'h001;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_DOWN_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        run && (cnt_ff != `FCP_CNT_RST) |=> cnt_ff == $past(cnt_ff) - 10'h001)
        else $error("counter did not step down by one");
    AST_AUTO_RELOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
        tim.uf_evt && !load_bit |=> cnt_ff == $past(shadow_ff))
        else $error("counter did not reload from counter register");
    AST_STOP_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        !run |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved while stopped");

endmodule : fcp_counter

/* File: hw/fcp_channel.sv */
// One PWM channel: compare shadow and output level decision
`include "fcp_defines.svh"

module fcp_channel (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire fcp_pkg::fcp_cnt_t channel_compare,
    fcp_cnt_if.snk tim,
    output logic nxt_level
);
    import fcp_pkg::*;

    fcp_cnt_t cmp_ff;

    // New width waits for the loaded underflow, avoiding mid-period glitches
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_ff <= `FCP_CMP_RST;
        end else if (tim.apply) begin
            cmp_ff <= channel_compare;
        end
    end

    // Low while compare exceeds count; all ones is forced low
    always_comb begin
        if (cmp_ff == `FCP_CMP_MAX) begin
            nxt_level = 1'b0;
        end else if (cmp_ff > tim.cnt) begin
            nxt_level = 1'b0;
        end else begin
            nxt_level = 1'b1;
        end
    end

    AST_ZERO_HIGH: assert property (@(posedge sys_clk) disable iff (!rstn)
        cmp_ff == `FCP_CMP_MIN |-> nxt_level)
        else $error("zero compare did not give high");
    AST_CMP_LATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        !tim.apply |=> cmp_ff == $past(cmp_ff))
        else $error("compare changed outside a loaded underflow");

endmodule : fcp_channel

/* File: hw/fcp_pwm.sv */
// Four-channel PWM generator with brake, top level
//
// What this block does
// - Four PWM channels, each compares its own value with one shared counter.
// - After reset every output takes the level of the reset-level strap.
// - Period counter is a 10-bit down counter stepping each clock, unprescaled.
// - Underflow reloads the counter from its counter register; period is value plus one.
// - Period value joins two high-register bits above eight low-register bits.
// - Run, load and underflow together load the period; load bit then self-clears.
// - Hardware sets the underflow flag at each underflow; only software clears it.
// - Output low while compare exceeds counter, high otherwise.
// - New compare values take effect at the next loaded underflow, not at once.
// - High pulse length is period value minus compare plus one clocks.
// - Compare zero holds high; compare all ones holds low.
// - Brake comes from a software bit or an external pin, under brake control.
// - Brake pin acts on low level with polarity clear, high level with it set.
// - Brake clears the run bit and sets the brake flag.
// - Brake flag is pollable and raises the brake interrupt when enabled.
// - Releasing brake leaves outputs at the levels they held just before it.
`include "fcp_defines.svh"

module fcp_pwm #(
    parameter int CNT_W = `FCP_CNT_W,
    parameter int NUM_CH = `FCP_NUM_CH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reset_level_select,
    input wire logic [`FCP_PER_HI_W-1:0] period_high_reg,
    input wire logic [`FCP_PER_LO_W-1:0] period_low_reg,
    input wire fcp_pkg::fcp_cmp_arr_t channel_compare,
    input wire logic run_set,
    input wire logic run_clr,
    input wire logic load_set,
    input wire logic underflow_clr,
    input wire logic brake_sw,
    input wire logic brake_pin_en,
    input wire logic brake_pin_polarity,
    input wire logic brake_pin,
    input wire logic brake_flag_clr,
    input wire logic brake_irq_en,
    output fcp_pkg::fcp_lvl_t pwm_out,
    output logic counter_run_bit,
    output logic load_bit,
    output logic underflow_flag,
    output logic brake_flag,
    output logic brake_irq,
    output fcp_pkg::fcp_cnt_t count_value
);
    import fcp_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The compare decode and the pin map are built for exactly this shape
    generate
        if (CNT_W != `FCP_CNT_W || NUM_CH != `FCP_NUM_CH) begin : g_bad_shape
            $error("fcp_pwm supports only a 10-bit counter with four channels");
        end
    endgenerate

    // ************************************************************
    // Declarations
    // ************************************************************
    fcp_state_e state_ff;
    fcp_state_e nxt_state;
    logic [`FCP_SYNC_W-1:0] strap_wait_ff;
    logic strap_meta_ff;
    logic strap_sync_ff;
    logic brk_meta_ff;
    logic brk_sync_ff;
    logic counter_run_bit_ff;
    logic nxt_run;
    logic load_bit_ff;
    logic underflow_flag_ff;
    logic brake_flag_ff;
    logic nxt_brake_flag;
    logic brake_irq_ff;
    fcp_lvl_t pwm_out_ff;
    fcp_lvl_t nxt_level;
    fcp_cnt_t period_value;
    logic brake_active;

    fcp_cnt_if tim ();

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Both pins come from outside, two flops before any logic looks at them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            brk_meta_ff <= 1'b0;
            brk_sync_ff <= 1'b0;
        end else begin
            brk_meta_ff <= brake_pin;
            brk_sync_ff <= brk_meta_ff;
        end
    end

    // Strap is a level caught after release, never during reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= reset_level_select;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // Counts edges until the strap has crossed both flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_wait_ff <= `FCP_SYNC_RST;
        end else if (strap_wait_ff != `FCP_STRAP_WAIT) begin
            strap_wait_ff <= strap_wait_ff + 2'h1;
        end
    end

    // ************************************************************
    // Brake source and period assembly
    // ************************************************************
    // Pin level compared against the polarity bit; software brake is level too
    assign brake_active = brake_sw || (brake_pin_en && (brk_sync_ff == brake_pin_polarity));
    assign period_value = {period_high_reg, period_low_reg};

    // ************************************************************
    // Control state machine
    // ************************************************************
    // Run may only restart once brake has gone; release lands in stop
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_INIT: begin
                if (strap_wait_ff == `FCP_STRAP_WAIT) begin
                    nxt_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (brake_active) begin
                    nxt_state = ST_BRAKE;
                end else if (run_set) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (brake_active) begin
                    nxt_state = ST_BRAKE;
                end else if (run_clr) begin
                    nxt_state = ST_STOP;
                end
            end
            ST_BRAKE: begin
                if (!brake_active) begin
                    nxt_state = ST_STOP;
                end
            end
            default: begin
                nxt_state = ST_INIT;
            end
        endcase
    end

    assign nxt_run = (nxt_state == ST_RUN);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_INIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Run bit follows the machine; brake entry clears it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            counter_run_bit_ff <= 1'b0;
        end else begin
            counter_run_bit_ff <= nxt_run;
        end
    end

    // ************************************************************
    // Counter and channels
    // ************************************************************
    fcp_counter u_counter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(counter_run_bit_ff),
        .load_bit(load_bit_ff),
        .period_value(period_value),
        .tim(tim)
    );

    // One compare slice per channel on the shared count
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            fcp_channel u_channel (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .channel_compare(channel_compare[ch]),
                .tim(tim),
                .nxt_level(nxt_level[ch])
            );
        end
    endgenerate

    // ************************************************************
    // Flags
    // ************************************************************
    // A new load request in the apply cycle survives, set wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            load_bit_ff <= 1'b0;
        end else if (load_set) begin
            load_bit_ff <= 1'b1;
        end else if (tim.apply) begin
            load_bit_ff <= 1'b0;
        end
    end

    // Sticky underflow; an underflow in the clear cycle is kept
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            underflow_flag_ff <= 1'b0;
        end else if (tim.uf_evt) begin
            underflow_flag_ff <= 1'b1;
        end else if (underflow_clr) begin
            underflow_flag_ff <= 1'b0;
        end
    end

    // Brake flag stays set while brake persists, even against a clear
    assign nxt_brake_flag = brake_active || (brake_flag_ff && !brake_flag_clr);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            brake_flag_ff <= 1'b0;
            brake_irq_ff <= 1'b0;
        end else begin
            brake_flag_ff <= nxt_brake_flag;
            brake_irq_ff <= nxt_brake_flag && brake_irq_en;
        end
    end

    // ************************************************************
    // Output levels
    // ************************************************************
    // Outputs follow compare only while running; brake and stop freeze them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwm_out_ff <= `FCP_PWM_RST;
        end else if (state_ff == ST_INIT && nxt_state == ST_STOP) begin
            pwm_out_ff <= {NUM_CH{strap_sync_ff}};
        end else if (counter_run_bit_ff) begin
            pwm_out_ff <= nxt_level;
        end
    end

    assign pwm_out = pwm_out_ff;
    assign counter_run_bit = counter_run_bit_ff;
    assign load_bit = load_bit_ff;
    assign underflow_flag = underflow_flag_ff;
    assign brake_flag = brake_flag_ff;
    assign brake_irq = brake_irq_ff;
    assign count_value = tim.cnt;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_brake_raise;
        brake_active && (state_ff == ST_RUN);
    endsequence

    sequence s_brake_taken;
        !counter_run_bit_ff && brake_flag_ff && (state_ff == ST_BRAKE);
    endsequence

    AST_BRAKE_STOPS_RUN: assert property (s_brake_raise |=> s_brake_taken)
        else $error("brake did not stop run and set flag");
    AST_BRAKE_IRQ: assert property (brake_flag_ff && $past(brake_irq_en) |-> brake_irq_ff)
        else $error("enabled brake flag gave no interrupt");
    AST_IRQ_NEEDS_FLAG: assert property (brake_irq_ff |-> brake_flag_ff)
        else $error("brake interrupt without brake flag");
    AST_BRAKE_FREEZE: assert property ((state_ff == ST_BRAKE) |=> pwm_out_ff == $past(pwm_out_ff))
        else $error("outputs moved during brake");
    AST_UF_SET: assert property (tim.uf_evt |=> underflow_flag_ff)
        else $error("underflow did not set flag");
    AST_UF_STICKY: assert property (underflow_flag_ff && !underflow_clr |=> underflow_flag_ff)
        else $error("underflow flag cleared by hardware");
    AST_LOAD_SELF_CLR: assert property (tim.apply && !load_set
        |=> !load_bit_ff ##0 tim.cnt == $past(period_value))
        else $error("load did not clear or period not loaded");
    AST_RESET_LEVEL: assert property ((state_ff == ST_STOP) && ($past(state_ff) == ST_INIT)
        |-> pwm_out_ff == {NUM_CH{$past(strap_sync_ff)}})
        else $error("outputs not at strap level after reset");
    AST_PIN_POLARITY: assert property (brake_pin_en && (brk_sync_ff == brake_pin_polarity) |=> brake_flag_ff)
        else $error("brake pin level ignored");
    AST_RUN_WAIT_INIT: assert property ((state_ff == ST_INIT) |-> !counter_run_bit_ff [*1] ##0 !tim.uf_evt)
        else $error("counter ran before start-up finished");

endmodule : fcp_pwm

/* File: bench/fcp_far_side.sv */
// Far-side model: external brake source wired to the generator's brake pin
module fcp_far_side (
    input wire logic sys_clk,
    input wire logic trip,
    input wire logic brake_pin_polarity,
    output logic brake_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pin_ff = 1'b1;

    // Idle level is the inverse of the active one, so a quiet source never reads as a brake
    always @(posedge sys_clk) begin
        pin_ff <= trip ? brake_pin_polarity : ~brake_pin_polarity;
    end

    assign brake_pin = pin_ff;
endmodule : fcp_far_side

/* File: bench/fcp_pwm_tb.sv */
// Self-checking bench for the four-channel PWM generator
`include "fcp_defines.svh"

module fcp_pwm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcp_pkg::*;

    // ************************************************************
    // Signals and scoreboard
    // ************************************************************
    typedef struct {string nm; logic [9:0] v;} fcp_note_s;
    typedef struct {logic [9:0] hi [4]; logic [9:0] per;} fcp_span_s;
    localparam logic [4:0] P_RUN = 5'h10, P_STOP = 5'h08, P_LOAD = 5'h04, P_UFC = 5'h02, P_BFC = 5'h01;

    logic sys_clk = 1'b0;
    logic rstn, reset_level_select, run_set, run_clr, load_set, underflow_clr, brake_sw;
    logic brake_pin_en, brake_pin_polarity, brake_pin, brake_flag_clr, brake_irq_en, trip;
    logic [`FCP_PER_HI_W-1:0] period_high_reg;
    logic [`FCP_PER_LO_W-1:0] period_low_reg;
    fcp_cmp_arr_t channel_compare;
    fcp_lvl_t pwm_out;
    logic counter_run_bit, load_bit, underflow_flag, brake_flag, brake_irq;
    fcp_cnt_t count_value;
    int err_count = 0;
    int n_compared = 0;
    int seed = 32'h60423EA6;
    fcp_note_s note_q[$];
    fcp_span_s span_q[$];
    logic [9:0] seen;
    event got;
    int cur_p = 0;
    bit prim = 1'b0;
    int hi_cnt [4];
    int plen = 0;

    // Clock at 10 MHz
    always #50 sys_clk = ~sys_clk;

    fcp_pwm fcp_pwm_inst (.sys_clk(sys_clk), .rstn(rstn), .reset_level_select(reset_level_select),
        .period_high_reg(period_high_reg), .period_low_reg(period_low_reg), .channel_compare(channel_compare),
        .run_set(run_set), .run_clr(run_clr), .load_set(load_set), .underflow_clr(underflow_clr),
        .brake_sw(brake_sw), .brake_pin_en(brake_pin_en), .brake_pin_polarity(brake_pin_polarity),
        .brake_pin(brake_pin), .brake_flag_clr(brake_flag_clr), .brake_irq_en(brake_irq_en),
        .pwm_out(pwm_out), .counter_run_bit(counter_run_bit), .load_bit(load_bit),
        .underflow_flag(underflow_flag), .brake_flag(brake_flag), .brake_irq(brake_irq),
        .count_value(count_value));

    fcp_far_side fcp_far_side_inst (.sys_clk(sys_clk), .trip(trip), .brake_pin_polarity(brake_pin_polarity),
        .brake_pin(brake_pin));

    // ************************************************************
    // Tasks
    // ************************************************************
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // One-cycle strobe on the chosen control pulses
    task pulse(input logic [4:0] m);
        @(posedge sys_clk);
        {run_set, run_clr, load_set, underflow_clr, brake_flag_clr} <= m;
        @(posedge sys_clk);
        {run_set, run_clr, load_set, underflow_clr, brake_flag_clr} <= 5'h00;
    endtask : pulse

    // Note the expectation, then hand the sampled value to the watcher
    task chk(input string nm, input logic [9:0] e, input logic [9:0] s);
        note_q.push_back('{nm, e});
        seen = s;
        -> got;
        #1;
    endtask : chk

    // High time per channel over one period, then wait until the monitor has used it
    task expect_span(input fcp_cmp_arr_t c, input int p);
        fcp_span_s s;
        int k;
        for (k = 0; k < 4; k++) begin
            s.hi[k] = (c[k] == 10'h3FF || int'(c[k]) > p) ? 10'h000 : 10'(p - int'(c[k]) + 1);
        end
        s.per = 10'(p + 1);
        cur_p = p;
        prim = 1'b0;
        span_q.push_back(s);
        for (k = 0; k < 4 * p + 40 && span_q.size() > 0; k++) @(negedge sys_clk);
        if (span_q.size() > 0) begin
            $display("[FAIL] span monitor expected boundary seen none");
            err_count++;
            span_q.delete();
        end
    endtask : expect_span

    task do_reset(input logic s);
        @(posedge sys_clk);
        rstn <= 1'b0;
        reset_level_select <= s;
        tick(8);
        @(negedge sys_clk);
        chk("pwm_out in reset", 10'h000, 10'(pwm_out));
        @(posedge sys_clk);
        rstn <= 1'b1;
        tick(4);
        @(negedge sys_clk);
        chk("pwm_out after reset", {6'h00, {4{s}}}, 10'(pwm_out));
    endtask : do_reset

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // Watchers
    // ************************************************************
    // Oldest note against the value just sampled
    always @(got) begin : note_mon
        fcp_note_s n;
        n = note_q.pop_front();
        n_compared++;
        if (n.v !== seen) begin
            $display("[FAIL] %s expected %h seen %h", n.nm, n.v, seen);
            err_count++;
        end
    end

    // Counts high samples between reloads; first boundary after each expect_span only aligns the window
    always @(negedge sys_clk) begin : span_mon
        fcp_span_s s;
        if (counter_run_bit === 1'b1) begin
            for (int k = 0; k < 4; k++) hi_cnt[k] += (pwm_out[k] === 1'b1) ? 1 : 0;
            plen++;
            if (count_value === 10'(cur_p)) begin
                if (prim && span_q.size() > 0) begin
                    s = span_q.pop_front();
                    for (int k = 0; k < 4; k++) begin
                        n_compared++;
                        if (s.hi[k] !== 10'(hi_cnt[k])) begin
                            $display("[FAIL] high time ch%0d expected %0d seen %0d", k, s.hi[k], hi_cnt[k]);
                            err_count++;
                        end
                    end
                    n_compared++;
                    if (s.per !== 10'(plen)) begin
                        $display("[FAIL] period expected %0d seen %0d", s.per, plen);
                        err_count++;
                    end
                end
                prim = 1'b1;
                for (int k = 0; k < 4; k++) hi_cnt[k] = 0;
                plen = 0;
            end
        end
    end

    // Cuts a hang short well beyond the expected run length
    initial begin : watchdog
        #(100 * 40000);
        err_count++;
        $display("[FAIL] run length expected finish seen timeout");
        test_done;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin : main
        int i;
        int k;
        int p2;
        fcp_cmp_arr_t nc;
        fcp_cmp_arr_t oc;
        fcp_cnt_t a;
        fcp_lvl_t frozen;
        {rstn, reset_level_select, run_set, run_clr, load_set, underflow_clr, brake_sw} = 7'h00;
        {brake_pin_en, brake_pin_polarity, brake_flag_clr, brake_irq_en, trip} = 5'h00;
        {period_high_reg, period_low_reg} = 10'h000;
        channel_compare = '0;
        for (i = 0; i < 2; i++) do_reset(i[0]);
        // Short period with the edge compare codes
        @(posedge sys_clk);
        {period_high_reg, period_low_reg} <= 10'h009;
        oc = {10'h3FF, 10'h009, 10'h003, 10'h000};
        channel_compare <= oc;
        pulse(P_LOAD);
        pulse(P_RUN);
        tick(2);
        @(negedge sys_clk);
        chk("load bit", 10'h000, 10'(load_bit));
        expect_span(oc, 9);
        // Stop holds the counter and raises no underflow
        pulse(P_STOP);
        @(negedge sys_clk);
        a = count_value;
        chk("underflow flag", 10'h001, 10'(underflow_flag));
        pulse(P_UFC);
        tick(20);
        @(negedge sys_clk);
        chk("flag while stopped", 10'h000, 10'(underflow_flag));
        chk("count while stopped", a, count_value);
        pulse(P_RUN);
        tick(12);
        @(negedge sys_clk);
        chk("underflow flag again", 10'h001, 10'(underflow_flag));
        a = count_value;
        @(negedge sys_clk);
        chk("count step", (a == 10'h000) ? 10'h009 : a - 10'h001, count_value);
        // New compares and period wait for the load bit
        for (k = 0; k < 4; k++) nc[k] = 10'($unsigned($random(seed)) % 300);
        p2 = 256 + int'($unsigned($random(seed)) % 29);
        @(posedge sys_clk);
        channel_compare <= nc;
        {period_high_reg, period_low_reg} <= 10'(p2);
        expect_span(oc, 9);
        pulse(P_LOAD);
        expect_span(nc, p2);
        @(negedge sys_clk);
        chk("load bit cleared", 10'h000, 10'(load_bit));
        // External pin brake at both polarities
        for (i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            brake_pin_en <= 1'b0;
            brake_pin_polarity <= i[0];
            brake_irq_en <= i[0];
            tick(4);
            brake_pin_en <= 1'b1;
            tick(4);
            @(negedge sys_clk);
            chk("idle pin", 10'h001, 10'(counter_run_bit));
            @(posedge sys_clk);
            trip <= 1'b1;
            for (k = 0; k < 8 && counter_run_bit === 1'b1; k++) @(negedge sys_clk);
            chk("run under brake", 10'h000, 10'(counter_run_bit));
            chk("brake flag", 10'h001, 10'(brake_flag));
            chk("brake irq", 10'(i[0]), 10'(brake_irq));
            frozen = pwm_out;
            pulse(P_RUN);
            @(negedge sys_clk);
            chk("run refused", 10'h000, 10'(counter_run_bit));
            @(posedge sys_clk);
            trip <= 1'b0;
            tick(6);
            pulse(P_BFC);
            @(negedge sys_clk);
            chk("brake flag cleared", 10'h000, 10'(brake_flag));
            chk("levels kept", 10'(frozen), 10'(pwm_out));
            pulse(P_RUN);
            @(negedge sys_clk);
            chk("run after release", 10'h001, 10'(counter_run_bit));
        end
        // Software brake with the pin disabled
        @(posedge sys_clk);
        brake_pin_en <= 1'b0;
        brake_sw <= 1'b1;
        tick(2);
        @(negedge sys_clk);
        chk("run under sw brake", 10'h000, 10'(counter_run_bit));
        chk("sw brake flag", 10'h001, 10'(brake_flag));
        test_done;
    end
endmodule : fcp_pwm_tb
